// >>> shared/usart_mode_regs.svh
`ifndef USART_MODE_REGS_SVH
`define USART_MODE_REGS_SVH

// Register byte offsets (APB, one aligned word each)
`define OFS_CHANNEL_CMD       8'h00
`define OFS_LINE_MODE_CONFIG  8'h04
`define OFS_IRQ_ENABLE_SET    8'h08
`define OFS_IRQ_ENABLE_CLEAR  8'h0c
`define OFS_IRQ_ENABLE_STATE  8'h10
`define OFS_CHANNEL_STATUS    8'h14

// Command register bits
`define CMD_RST_STATUS_BIT    8
`define CMD_RST_RETRY_BIT     13
`define CMD_RST_NEG_ACK_SEEN_BIT      14

// Line mode fields
`define MODE_USART_MODE_LSB   0
`define MODE_CLK_SRC_LSB      4
`define MODE_CHAR_LEN_LSB     6
`define MODE_SYNC_BIT         8
`define MODE_STOP_LSB         12
`define MODE_CHANNEL_TEST_MODE_LSB       14
`define MODE_MSB_FIRST_BIT    16
`define MODE_NINE_BIT         17
`define MODE_CLK_OUT_BIT      18
`define MODE_OVER_BIT         19
`define MODE_NEG_ACK_SEEN_INH_BIT     20
`define MODE_REPEAT_LIM_BIT   21
`define MODE_MAX_RETRY_LSB    24
`define MODE_FILTER_BIT       28
`define MODE_WRITE_MASK       32'h173fffff
`define MODE_RESET            32'h00000000

// Field codes
`define USART_MODE_ISO_T0     4'h4
`define CLK_SRC_EXTERNAL      2'h3
`define STOP_CODE_ONE         2'h0
`define STOP_CODE_ONE_HALF    2'h1
`define STOP_CODE_TWO         2'h2

// Shared interrupt bit map
`define ST_RX_CHAR_READY      0
`define ST_TX_HOLDING_FREE    1
`define ST_RX_BREAK           2
`define ST_RX_DMA_END         3
`define ST_TX_DMA_END         4
`define ST_OVERRUN            5
`define ST_FRAMING            6
`define ST_PARITY             7
`define ST_TIMEOUT            8
`define ST_TX_ALL_EMPTY       9
`define ST_RETRY_LIMIT        10
`define ST_TX_DMA_BUF_EMPTY   11
`define ST_RX_DMA_BUF_FULL    12
`define ST_NEG_ACK_SEEN       13
`define ST_CHANGE_LSB         16
`define ST_LEVEL_LSB          20
`define IRQ_VALID_BITS        32'h000f3fff
`define IRQ_MASK_RESET        32'h00000000

// Receiver oversampling ratios
`define OVERSAMPLE_NORMAL     5'd16
`define OVERSAMPLE_FAST       5'd8

`endif

// >>> shared/usart_mode_pkg.sv
package usart_mode_pkg;

	// Channel test mode, in field code order
	typedef enum logic [1:0] {CH_NORMAL, CH_ECHO, CH_LOCAL, CH_REMOTE} chan_mode_e;

	// Events and levels reported by the serial core
	typedef struct packed {
		logic rx_char_ready;
		logic tx_holding_free;
		logic rx_break_flag;
		logic rx_dma_end;
		logic tx_dma_end;
		logic overrun_err;
		logic framing_err;
		logic parity_err;
		logic timeout;
		logic tx_all_empty;
		logic tx_dma_buf_empty;
		logic rx_dma_buf_full;
		logic neg_ack_seen;
		logic rx_char_done;
	} core_events_s;

	// Decoded line configuration towards the serial core
	typedef struct packed {
		logic [2:0] stop_half_bits;
		logic       stop_reserved;
		logic       sync_mode;
		logic       msb_first;
		logic [3:0] char_bits;
		logic [4:0] oversample;
		logic       rx_enable;
		logic       tx_enable;
	} line_cfg_s;

	// Modem control inputs
	typedef struct packed {
		logic clear_to_send;
		logic carrier_detect;
		logic dataset_ready;
		logic ring_ind;
	} modem_lines_s;

endpackage

// >>> hdl/usart_mode_irq.sv
// The APB register port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "usart_mode_regs.svh"

module usart_mode_irq
	import usart_mode_pkg::*;
(
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// APB slave
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	// Serial core side
	input  wire core_events_s core_ev,
	input  wire logic         tx_core_out,
	input  wire logic         baud_clk_in,
	input  wire logic         filter_tick,
	output line_cfg_s         line_cfg,
	output logic              rx_core_in,
	output logic              neg_ack_seen_send,
	// Line pins
	input  wire logic         rxd_pin,
	output logic              txd_pin,
	output logic              sck_out,
	output logic              sck_oe,
	input  wire modem_lines_s modem_pins,
	// Interrupt request
	output logic              irq
);

	//--------------------------------------------------------------
	// Register state
	//--------------------------------------------------------------
	logic [31:0]  mode_q;
	logic [31:0]  mask_q;
	logic [31:0]  prdata_q;
	logic         pready_q;
	logic         pslverr_q;
	logic         rx_break_q;
	logic         overrun_q;
	logic         framing_q;
	logic         parity_q;
	logic         retry_limit_q;
	logic         neg_ack_seen_flag_q;
	logic [3:0]   change_q;
	logic [2:0]   retry_cnt_q;
	logic         neg_ack_seen_send_q;
	logic         irq_q;
	line_cfg_s    line_cfg_q;
	logic         txd_q;
	logic         rx_core_q;
	logic         sck_out_q;
	logic         sck_oe_q;

	// Synchronisers and filter
	logic         rxd_meta_q;
	logic         rxd_sync_q;
	logic [2:0]   rxd_samples_q;
	modem_lines_s modem_meta_q;
	modem_lines_s modem_sync_q;
	modem_lines_s modem_prev_q;

	//--------------------------------------------------------------
	// Bus decode
	//--------------------------------------------------------------
	logic         access;
	logic         done;
	logic         wr_done;
	logic         rd_done;
	logic         mapped;
	logic [31:0]  status;
	logic [31:0]  rdata_d;
	chan_mode_e   chan_mode;
	logic         rx_filtered;
	logic         iso_t0;

	// One wait state: data is captured in the first access cycle
	assign access  = psel && penable && !pready_q;
	assign done    = psel && penable && pready_q;
	assign wr_done = done && pwrite && !pslverr_q;
	assign rd_done = done && !pwrite && !pslverr_q;

	// Address map check
	always_comb
	begin
		case (paddr)
			`OFS_CHANNEL_CMD,
			`OFS_LINE_MODE_CONFIG,
			`OFS_IRQ_ENABLE_SET,
			`OFS_IRQ_ENABLE_CLEAR,
			`OFS_IRQ_ENABLE_STATE,
			`OFS_CHANNEL_STATUS: mapped = 1'b1;
			default:             mapped = 1'b0;
		endcase
	end

	// Status word, one bit map for all interrupt registers
	always_comb
	begin
		status = 32'h00000000;
		status[`ST_RX_CHAR_READY]    = core_ev.rx_char_ready;
		status[`ST_TX_HOLDING_FREE]  = core_ev.tx_holding_free;
		status[`ST_RX_BREAK]         = rx_break_q;
		status[`ST_RX_DMA_END]       = core_ev.rx_dma_end;
		status[`ST_TX_DMA_END]       = core_ev.tx_dma_end;
		status[`ST_OVERRUN]          = overrun_q;
		status[`ST_FRAMING]          = framing_q;
		status[`ST_PARITY]           = parity_q;
		status[`ST_TIMEOUT]          = core_ev.timeout;
		status[`ST_TX_ALL_EMPTY]     = core_ev.tx_all_empty;
		status[`ST_RETRY_LIMIT]      = retry_limit_q;
		status[`ST_TX_DMA_BUF_EMPTY] = core_ev.tx_dma_buf_empty;
		status[`ST_RX_DMA_BUF_FULL]  = core_ev.rx_dma_buf_full;
		status[`ST_NEG_ACK_SEEN]     = neg_ack_seen_flag_q;
		status[`ST_CHANGE_LSB +: 4]  = change_q;
		status[`ST_LEVEL_LSB +: 4]   = modem_sync_q;
	end

	// Read multiplexer; write-only registers read as zero
	always_comb
	begin
		case (paddr)
			`OFS_LINE_MODE_CONFIG: rdata_d = mode_q;
			`OFS_IRQ_ENABLE_STATE: rdata_d = mask_q;
			`OFS_CHANNEL_STATUS:   rdata_d = status;
			default:               rdata_d = 32'h00000000;
		endcase
	end

	//--------------------------------------------------------------
	// APB answer
	//--------------------------------------------------------------
	// Ready, error and read data all come from flops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h00000000;
		end
		else
		begin
			pready_q  <= access;
			pslverr_q <= access && !mapped;
			if (access && !pwrite)
				prdata_q <= mapped ? rdata_d : 32'h00000000;
		end
	end

	//--------------------------------------------------------------
	// Configuration registers
	//--------------------------------------------------------------
	// Line mode register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mode_q <= `MODE_RESET;
		else if (wr_done && paddr == `OFS_LINE_MODE_CONFIG)
			mode_q <= pwdata & `MODE_WRITE_MASK;
	end

	// Interrupt mask: set and clear through separate addresses
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mask_q <= `IRQ_MASK_RESET;
		else if (wr_done && paddr == `OFS_IRQ_ENABLE_SET)
			mask_q <= mask_q | (pwdata & `IRQ_VALID_BITS);
		else if (wr_done && paddr == `OFS_IRQ_ENABLE_CLEAR)
			mask_q <= mask_q & ~(pwdata & `IRQ_VALID_BITS);
	end

	//--------------------------------------------------------------
	// Sticky status flags
	//--------------------------------------------------------------
	logic cmd_wr;
	logic rst_status;
	logic rst_retry;
	logic rst_neg_ack_seen;

	assign cmd_wr     = wr_done && paddr == `OFS_CHANNEL_CMD;
	assign rst_status = cmd_wr && pwdata[`CMD_RST_STATUS_BIT];
	assign rst_retry  = cmd_wr && pwdata[`CMD_RST_RETRY_BIT];
	assign rst_neg_ack_seen   = cmd_wr && pwdata[`CMD_RST_NEG_ACK_SEEN_BIT];

	// Receive error flags; a new event wins over the clear command
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_break_q <= 1'b0;
			overrun_q  <= 1'b0;
			framing_q  <= 1'b0;
			parity_q   <= 1'b0;
		end
		else
		begin
			rx_break_q <= core_ev.rx_break_flag || (rx_break_q && !rst_status);
			overrun_q  <= core_ev.overrun_err || (overrun_q && !rst_status);
			framing_q  <= core_ev.framing_err || (framing_q && !rst_status);
			parity_q   <= core_ev.parity_err || (parity_q && !rst_status);
		end
	end

	// Negative acknowledge seen flag
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			neg_ack_seen_flag_q <= 1'b0;
		else
			neg_ack_seen_flag_q <= core_ev.neg_ack_seen || (neg_ack_seen_flag_q && !rst_neg_ack_seen);
	end

	// Modem change flags: only bits already reported by a read are cleared,
	// so an edge between capture and completion is not lost
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			change_q     <= 4'h0;
			modem_prev_q <= '0;
		end
		else
		begin
			modem_prev_q <= modem_sync_q;
			if (rd_done && paddr == `OFS_CHANNEL_STATUS)
				change_q <= (change_q & ~prdata_q[`ST_CHANGE_LSB +: 4]) | (modem_sync_q ^ modem_prev_q);
			else
				change_q <= change_q | (modem_sync_q ^ modem_prev_q);
		end
	end

	//--------------------------------------------------------------
	// Smart-card negative acknowledge
	//--------------------------------------------------------------
	assign iso_t0 = mode_q[`MODE_USART_MODE_LSB +: 4] == `USART_MODE_ISO_T0;

	// Successive error count; a clean character restarts it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			retry_cnt_q   <= 3'h0;
			retry_limit_q <= 1'b0;
			neg_ack_seen_send_q   <= 1'b0;
		end
		else
		begin
			neg_ack_seen_send_q <= 1'b0;
			if (core_ev.rx_char_done && !core_ev.parity_err)
				retry_cnt_q <= 3'h0;
			if (core_ev.parity_err && !mode_q[`MODE_NEG_ACK_SEEN_INH_BIT])
			begin
				if (!mode_q[`MODE_REPEAT_LIM_BIT] || !iso_t0)
					neg_ack_seen_send_q <= 1'b1;
				else if (retry_cnt_q < mode_q[`MODE_MAX_RETRY_LSB +: 3])
				begin
					neg_ack_seen_send_q <= 1'b1;
					retry_cnt_q <= retry_cnt_q + 3'h1;
				end
			end
			if (rst_retry)
				retry_cnt_q <= 3'h0;
			// Flag set on reaching the limit wins over the reset command
			if (core_ev.parity_err && !mode_q[`MODE_NEG_ACK_SEEN_INH_BIT] && mode_q[`MODE_REPEAT_LIM_BIT]
				&& iso_t0 && retry_cnt_q >= mode_q[`MODE_MAX_RETRY_LSB +: 3])
				retry_limit_q <= 1'b1;
			else if (rst_retry)
				retry_limit_q <= 1'b0;
		end
	end

	//--------------------------------------------------------------
	// Receive line synchroniser and infrared filter
	//--------------------------------------------------------------
	// Pins pass two flops before any logic looks at them
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rxd_meta_q   <= 1'b1;
			rxd_sync_q   <= 1'b1;
			modem_meta_q <= '0;
			modem_sync_q <= '0;
		end
		else
		begin
			rxd_meta_q   <= rxd_pin;
			rxd_sync_q   <= rxd_meta_q;
			modem_meta_q <= modem_pins;
			modem_sync_q <= modem_meta_q;
		end
	end

	// Three samples at the 1/16 bit tick
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rxd_samples_q <= 3'h7;
		else if (filter_tick)
			rxd_samples_q <= {rxd_samples_q[1:0], rxd_sync_q};
	end

	// Majority vote; unfiltered line bypasses it
	assign rx_filtered = mode_q[`MODE_FILTER_BIT] ?
		((rxd_samples_q[0] & rxd_samples_q[1]) | (rxd_samples_q[1] & rxd_samples_q[2]) |
		 (rxd_samples_q[0] & rxd_samples_q[2])) : rxd_sync_q;

	//--------------------------------------------------------------
	// Channel test modes
	//--------------------------------------------------------------
	assign chan_mode = chan_mode_e'(mode_q[`MODE_CHANNEL_TEST_MODE_LSB +: 2]);

	// Routing of transmit pin and receiver input; line idles high
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			txd_q     <= 1'b1;
			rx_core_q <= 1'b1;
		end
		else
		begin
			case (chan_mode)
				CH_NORMAL:
				begin
					txd_q     <= tx_core_out;
					rx_core_q <= rx_filtered;
				end
				CH_ECHO:
				begin
					txd_q     <= rx_filtered;
					rx_core_q <= rx_filtered;
				end
				CH_LOCAL:
				begin
					txd_q     <= 1'b1;
					rx_core_q <= tx_core_out;
				end
				CH_REMOTE:
				begin
					txd_q     <= rx_filtered;
					rx_core_q <= 1'b1;
				end
				default:
				begin
					txd_q     <= 1'b1;
					rx_core_q <= 1'b1;
				end
			endcase
		end
	end

	//--------------------------------------------------------------
	// Decoded configuration and serial clock
	//--------------------------------------------------------------
	// Decoded fields are registered so the core sees clean levels
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			line_cfg_q <= '0;
		else
		begin
			line_cfg_q.sync_mode     <= mode_q[`MODE_SYNC_BIT];
			line_cfg_q.stop_reserved <= 1'b0;
			case (mode_q[`MODE_STOP_LSB +: 2])
				`STOP_CODE_ONE:      line_cfg_q.stop_half_bits <= 3'd2;
				`STOP_CODE_TWO:      line_cfg_q.stop_half_bits <= 3'd4;
				`STOP_CODE_ONE_HALF:
				begin
					line_cfg_q.stop_half_bits <= 3'd3;
					line_cfg_q.stop_reserved  <= mode_q[`MODE_SYNC_BIT];
				end
				default:
				begin
					line_cfg_q.stop_half_bits <= 3'd2;
					line_cfg_q.stop_reserved  <= 1'b1;
				end
			endcase
			line_cfg_q.msb_first  <= mode_q[`MODE_MSB_FIRST_BIT];
			line_cfg_q.char_bits  <= mode_q[`MODE_NINE_BIT] ? 4'd9 :
				4'd5 + {2'b00, mode_q[`MODE_CHAR_LEN_LSB +: 2]};
			line_cfg_q.oversample <= mode_q[`MODE_OVER_BIT] ?
				`OVERSAMPLE_FAST : `OVERSAMPLE_NORMAL;
			// Remote loopback leaves both halves of the core idle
			line_cfg_q.rx_enable  <= chan_mode != CH_REMOTE;
			line_cfg_q.tx_enable  <= chan_mode != CH_REMOTE;
		end
	end

	// Serial clock pin: never driven against an external clock source
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sck_oe_q  <= 1'b0;
			sck_out_q <= 1'b0;
		end
		else
		begin
			sck_oe_q  <= mode_q[`MODE_CLK_OUT_BIT] &&
				mode_q[`MODE_CLK_SRC_LSB +: 2] != `CLK_SRC_EXTERNAL;
			sck_out_q <= baud_clk_in;
		end
	end

	//--------------------------------------------------------------
	// Interrupt request
	//--------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_q <= 1'b0;
		else
			irq_q <= |(status & mask_q);
	end

	// Outputs
	assign prdata     = prdata_q;
	assign pready     = pready_q;
	assign pslverr    = pslverr_q;
	assign line_cfg   = line_cfg_q;
	assign rx_core_in = rx_core_q;
	assign neg_ack_seen_send  = neg_ack_seen_send_q;
	assign txd_pin    = txd_q;
	assign sck_out    = sck_out_q;
	assign sck_oe     = sck_oe_q;
	assign irq        = irq_q;

endmodule // usart_mode_irq

// >>> sim/usart_mode_irq_sva.sv
`timescale 1ns/100ps
`include "usart_mode_regs.svh"
module usart_mode_irq_chk
	import usart_mode_pkg::*;
(
	// Clock and reset
	input wire logic         pclk,
	input wire logic         presetn,
	// APB
	input wire logic         psel,
	input wire logic         penable,
	input wire logic         pwrite,
	input wire logic [7:0]   paddr,
	input wire logic [31:0]  pwdata,
	input wire logic [31:0]  prdata,
	input wire logic         pready,
	input wire logic         pslverr,
	// Core side
	input wire core_events_s core_ev,
	input wire logic         tx_core_out,
	input wire logic         baud_clk_in,
	input wire logic         filter_tick,
	input wire line_cfg_s    line_cfg,
	input wire logic         rx_core_in,
	input wire logic         neg_ack_seen_send,
	// Pins
	input wire logic         rxd_pin,
	input wire logic         txd_pin,
	input wire logic         sck_out,
	input wire logic         sck_oe,
	input wire modem_lines_s modem_pins,
	input wire logic         irq
);
	logic        done;
	logic [31:0] mode_q;
	logic [31:0] msk_q;
	logic [2:0]  age_q;
	logic [1:0]  st;
	assign done = psel && penable && pready && pwrite;
	assign st = mode_q[13:12];

	// Mirror of the mode word; age lets routing settle before it is judged
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			mode_q <= 32'h0;
			age_q  <= 3'h0;
		end
		else if (done && paddr == `OFS_LINE_MODE_CONFIG)
		begin
			mode_q <= pwdata & `MODE_WRITE_MASK;
			age_q  <= 3'h0;
		end
		else if (age_q != 3'h7)
			age_q <= age_q + 3'h1;

	// Mirror of the enable mask from set and clear writes
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			msk_q <= 32'h0;
		else if (done && paddr == `OFS_IRQ_ENABLE_SET)
			msk_q <= msk_q | (pwdata & `IRQ_VALID_BITS);
		else if (done && paddr == `OFS_IRQ_ENABLE_CLEAR)
			msk_q <= msk_q & ~pwdata;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_wait;
		psel && penable && !pready;
	endsequence
	property p_wait;
		s_wait |=> pready;
	endproperty
	a_wait: assert property (p_wait) else $error("pready late");
	property p_err;
		psel && penable && pready |-> pslverr == (paddr > `OFS_CHANNEL_STATUS || paddr[1:0] != 2'h0);
	endproperty
	a_err: assert property (p_err) else $error("pslverr wrong");
	property p_rst_mask;
		$rose(presetn) |-> !irq [*3];
	endproperty
	a_rst_mask: assert property (p_rst_mask) else $error("irq after reset");
	property p_irq_off;
		msk_q == 32'h0 && $past(msk_q) == 32'h0 |-> !irq;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq with mask clear");
	property p_neg_ack_seen_src;
		neg_ack_seen_send |-> $past(core_ev.parity_err);
	endproperty
	a_neg_ack_seen_src: assert property (p_neg_ack_seen_src) else $error("neg_ack_seen without parity error");
	property p_neg_ack_seen_inh;
		core_ev.parity_err && mode_q[20] |-> ##1 !neg_ack_seen_send;
	endproperty
	a_neg_ack_seen_inh: assert property (p_neg_ack_seen_inh) else $error("neg_ack_seen not inhibited");
	property p_neg_ack_seen_plain;
		core_ev.parity_err && !mode_q[20] && !(mode_q[3:0] == 4'h4 && mode_q[21])
			|-> ##1 neg_ack_seen_send;
	endproperty
	a_neg_ack_seen_plain: assert property (p_neg_ack_seen_plain) else $error("neg_ack_seen missing");
	property p_stop;
		age_q >= 3'h2 |-> line_cfg.stop_reserved == (st == 2'h3 || (st == 2'h1 && mode_q[8]))
			&& (st == 2'h1 || line_cfg.stop_half_bits == (st == 2'h2 ? 3'd4 : 3'd2))
			&& (st != 2'h1 || mode_q[8] || line_cfg.stop_half_bits == 3'd3);
	endproperty
	a_stop: assert property (p_stop) else $error("stop bits wrong");
	property p_order;
		age_q >= 3'h2 |-> line_cfg.msb_first == mode_q[16];
	endproperty
	a_order: assert property (p_order) else $error("bit order wrong");
	property p_len;
		age_q >= 3'h2 |-> line_cfg.char_bits == (mode_q[17] ? 4'd9 : 4'd5 + {2'b0, mode_q[7:6]});
	endproperty
	a_len: assert property (p_len) else $error("char length wrong");
	property p_over;
		age_q >= 3'h2 |-> line_cfg.oversample == (mode_q[19] ? 5'd8 : 5'd16);
	endproperty
	a_over: assert property (p_over) else $error("oversampling wrong");
	property p_clk;
		age_q >= 3'h2 |-> sck_oe == (mode_q[18] && mode_q[5:4] != `CLK_SRC_EXTERNAL);
	endproperty
	a_clk: assert property (p_clk) else $error("clock drive wrong");
	property p_echo;
		age_q >= 3'h4 && !mode_q[28] && mode_q[14] |-> txd_pin == $past(rxd_pin, 3);
	endproperty
	a_echo: assert property (p_echo) else $error("receive line not looped out");
	property p_local;
		age_q >= 3'h2 && mode_q[15:14] == 2'h2 |-> rx_core_in == $past(tx_core_out);
	endproperty
	a_local: assert property (p_local) else $error("local loop wrong");
	property p_sck_follow;
		$past(presetn) |-> sck_out == $past(baud_clk_in);
	endproperty
	a_sck_follow: assert property (p_sck_follow) else $error("serial clock not passed out");
	property p_remote;
		age_q >= 3'h2 |-> line_cfg.sync_mode == mode_q[8] && line_cfg.rx_enable == (mode_q[15:14] != 2'h3)
			&& line_cfg.tx_enable == line_cfg.rx_enable && (mode_q[15:14] != 2'h3 || rx_core_in);
	endproperty
	a_remote: assert property (p_remote) else $error("remote loop core state wrong");
endmodule // usart_mode_irq_chk

bind usart_mode_irq usart_mode_irq_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.core_ev(core_ev), .tx_core_out(tx_core_out), .baud_clk_in(baud_clk_in), .filter_tick(filter_tick),
	.line_cfg(line_cfg), .rx_core_in(rx_core_in), .neg_ack_seen_send(neg_ack_seen_send), .rxd_pin(rxd_pin), .txd_pin(txd_pin),
	.sck_out(sck_out), .sck_oe(sck_oe), .modem_pins(modem_pins), .irq(irq));

// >>> sim/line_partner.sv
`timescale 1ns/100ps
module line_partner
	import usart_mode_pkg::*;
(
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Bench controls
	input  wire logic         stream_en,
	input  wire logic         slow,
	input  wire modem_lines_s modem_set,
	// Line side
	output logic              rxd_pin,
	output modem_lines_s      modem_pins
);
	logic [7:0] lfsr_q;
	logic [1:0] lag_q;

	// Terminal sends noise-like bits while streaming, idles at mark level
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			lfsr_q  <= 8'h5a;
			rxd_pin <= 1'b1;
		end
		else
		begin
			lfsr_q  <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
			rxd_pin <= stream_en ? lfsr_q[0] : 1'b1;
		end

	// Modem answers at once, or only every fourth cycle when slow
	// Divider is reset so slow mode never stalls on an unknown count
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			lag_q      <= 2'h0;
			modem_pins <= '0;
		end
		else
		begin
			lag_q <= lag_q + 2'h1;
			if (!slow || lag_q == 2'h0)
				modem_pins <= modem_set;
		end
endmodule // line_partner

// >>> sim/tb_top.sv
`timescale 1ns/100ps
`include "usart_mode_regs.svh"
module tb_top
	import usart_mode_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]   paddr = 0;
	logic [31:0]  pwdata = 0, prdata, v, r, d, seed = 32'h7;
	logic         pready, pslverr, tx_core_out = 0, baud_clk_in = 0, filter_tick = 0;
	logic         rx_core_in, neg_ack_seen_send, rxd_pin, txd_pin, sck_out, sck_oe, irq;
	logic         stream_en = 1, slow = 0;
	core_events_s core_ev = '0;
	line_cfg_s    line_cfg;
	modem_lines_s modem_pins, modem_set = '0;
	logic [64:0]  exp_q[$];
	logic [64:0]  ent;
	logic [7:0]   cyc = 0;
	int           miscompares = 0, total_checks = 0, neg_ack_seen_cnt = 0, neg_ack_seen_exp = 0;

	usart_mode_irq dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_ev(core_ev),
		.tx_core_out(tx_core_out), .baud_clk_in(baud_clk_in), .filter_tick(filter_tick), .line_cfg(line_cfg),
		.rx_core_in(rx_core_in), .neg_ack_seen_send(neg_ack_seen_send), .rxd_pin(rxd_pin), .txd_pin(txd_pin),
		.sck_out(sck_out), .sck_oe(sck_oe), .modem_pins(modem_pins), .irq(irq));
	line_partner far (.pclk(pclk), .presetn(presetn), .stream_en(stream_en), .slow(slow),
		.modem_set(modem_set), .rxd_pin(rxd_pin), .modem_pins(modem_pins));

	always #5 pclk = ~pclk;

	// Free-running core traffic so loop paths always carry changing data
	always @(posedge pclk)
	begin
		cyc         <= cyc + 8'h1;
		tx_core_out <= cyc[1] ^ cyc[4];
		baud_clk_in <= cyc[0];
		filter_tick <= (cyc[3:0] == 4'hf);
		if (neg_ack_seen_send === 1'b1)
			neg_ack_seen_cnt++;
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// One APB transfer; a read notes its expected word under a compare mask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
		int n;
		@(posedge pclk);
		psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= e;
		if (!wr)
			exp_q.push_back({a > `OFS_CHANNEL_STATUS, m, e & m});
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 16);
		psel <= 0; penable <= 0;
		if (n >= 16)
		begin
			miscompares++;
			$display("ERROR pready expected 1 seen timeout");
			wrap_up();
		end
	endtask

	// Monitor takes the oldest note at each read completion
	always @(posedge pclk)
		if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
		begin
			ent = exp_q.pop_front();
			cmp("prdata", ent[31:0], prdata & ent[63:32]);
			cmp("pslverr", {31'h0, ent[64]}, {31'h0, pslverr});
		end

	task automatic parity_hits(input int k, input int nacks);
		repeat (k)
		begin
			@(posedge pclk); core_ev.parity_err <= 1;
			@(posedge pclk); core_ev.parity_err <= 0;
			repeat (4) @(posedge pclk);
		end
		neg_ack_seen_exp += nacks;
		cmp("neg_ack_seen_count", neg_ack_seen_exp, neg_ack_seen_cnt);
	endtask

	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1;
		apb(0, `OFS_IRQ_ENABLE_STATE, 0);
		apb(0, `OFS_LINE_MODE_CONFIG, `MODE_RESET);
		apb(0, 8'h40, 0);
		$display("test reset done");
		for (int i = 0; i < 8; i++)
		begin
			v = xs();
			v[13:12] = i[1:0];
			v[15:14] = i[2:1];
			v[8] = i[0];
			apb(1, `OFS_LINE_MODE_CONFIG, v);
			repeat (8) @(posedge pclk);
			apb(0, `OFS_LINE_MODE_CONFIG, v & `MODE_WRITE_MASK);
		end
		apb(1, `OFS_LINE_MODE_CONFIG, 0);
		$display("test mode done");
		r = xs() & `IRQ_VALID_BITS;
		d = xs();
		apb(1, `OFS_IRQ_ENABLE_SET, r);
		apb(1, `OFS_IRQ_ENABLE_SET, 0);
		apb(0, `OFS_IRQ_ENABLE_STATE, r);
		apb(1, `OFS_IRQ_ENABLE_CLEAR, d);
		apb(1, `OFS_IRQ_ENABLE_STATE, '1);
		apb(0, `OFS_IRQ_ENABLE_STATE, r & ~d);
		apb(1, `OFS_IRQ_ENABLE_SET, '1);
		apb(0, `OFS_IRQ_ENABLE_STATE, `IRQ_VALID_BITS);
		apb(1, `OFS_IRQ_ENABLE_CLEAR, '1);
		apb(1, `OFS_IRQ_ENABLE_SET, 32'h1);
		core_ev.rx_char_ready <= 1;
		repeat (3) @(posedge pclk);
		cmp("irq", 1, {31'h0, irq});
		apb(0, `OFS_CHANNEL_STATUS, 1, 1);
		apb(1, `OFS_IRQ_ENABLE_CLEAR, 32'h1);
		repeat (3) @(posedge pclk);
		cmp("irq", 0, {31'h0, irq});
		core_ev.rx_char_ready <= 0;
		$display("test interrupt done");
		apb(0, `OFS_CHANNEL_STATUS, 0, 32'h00f00000);
		modem_set <= 4'b1010;
		repeat (6) @(posedge pclk);
		apb(0, `OFS_CHANNEL_STATUS, 32'h00aa0000, 32'h00ff0000);
		apb(0, `OFS_CHANNEL_STATUS, 32'h00a00000, 32'h00ff0000);
		slow <= 1;
		modem_set <= 4'b0000;
		repeat (12) @(posedge pclk);
		apb(0, `OFS_CHANNEL_STATUS, 32'h000a0000, 32'h00ff0000);
		$display("test modem done");
		parity_hits(1, 1);
		apb(1, `OFS_LINE_MODE_CONFIG, 32'h1 << `MODE_NEG_ACK_SEEN_INH_BIT);
		parity_hits(1, 0);
		apb(1, `OFS_LINE_MODE_CONFIG, 32'h02200004);
		parity_hits(3, 2);
		apb(0, `OFS_CHANNEL_STATUS, 32'h480, 32'h480);
		apb(1, `OFS_CHANNEL_CMD, 32'h00002100);
		apb(0, `OFS_CHANNEL_STATUS, 0, 32'h480);
		apb(1, `OFS_LINE_MODE_CONFIG, 32'h02200000);
		parity_hits(3, 3);
		$display("test neg_ack_seen done");
		wrap_up();
	end
endmodule // tb_top
